/* File: hw/bttq_pkg.sv */
`default_nettype none
package bttq_pkg;
    // ==========================================
    // timing
    localparam int CLK_NS     = 20;
    localparam int US_NS      = 1000;
    localparam int CYC_PER_US = (US_NS + CLK_NS - 1) / CLK_NS;

    // ==========================================
    // register map (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_POST = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_QUAL = 8'h40;
    localparam logic [7:0] OFS_TRIG = 8'h80;
    localparam logic [1:0] REG_QUAL = 2'h1;
    localparam logic [1:0] REG_TRIG = 2'h2;

    // ==========================================
    // field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_ABORT = 1;
    localparam int CB_IOX     = 6;
    localparam int CB_WRITE   = 5;
    localparam int CB_CPU     = 4;
    localparam int CB_FETCH   = 3;
    localparam int CB_APT     = 2;
    localparam int CB_ION     = 1;
    localparam int CB_PON     = 0;
    localparam int W_EN       = 31;
    localparam int W_LOGICAL  = 30;

    // ==========================================
    // reset values and constants
    localparam logic [31:0] F2_RST    = 32'hFFFF_0000;
    localparam logic [31:0] F3_RST    = 32'h000F_0000;
    localparam logic [31:0] F3_Q0_RST = 32'h800F_0000;
    localparam logic [15:0] POST_RST  = 16'h0000;
    localparam logic [3:0]  LVL17     = 4'hF;
    localparam logic [2:0]  SEQ_MIN   = 3'h2;
    localparam logic [2:0]  SEQ_MAX   = 3'h4;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLV  = 2'h2;

    typedef enum logic [2:0] {QM_NORMAL, QM_DDIFF, QM_DINT, QM_LAINT, QM_PAINT, QM_ARM} bttq_qmode_t;
    typedef enum logic [2:0] {TM_NORMAL, TM_DDIFF, TM_DINT, TM_LAINT, TM_PAINT, TM_SEQ, TM_IOF,
                              TM_LVL17} bttq_tmode_t;
    typedef enum logic [2:0] {ST_IDLE, ST_ARMWAIT, ST_COLLECT, ST_POST, ST_DONE} bttq_state_t;

    typedef struct packed {
        logic [4:0]  pwr;
        logic [2:0]  seq_len;
        logic        seq_qual;
        bttq_tmode_t tmode;
        logic        ptab_only;
        bttq_qmode_t qmode;
    } bttq_mode_t;

    typedef struct packed {
        logic [15:0] data;
        logic [15:0] paddr;
        logic [15:0] laddr;
        logic [7:0]  bank;
        logic [1:0]  ptab;
        logic [6:0]  ctl;
        logic [3:0]  level;
        logic        ptab_ref;
    } bttq_cycle_t;

    localparam bttq_mode_t MODE_RST = '0;
endpackage
`default_nettype wire

/* File: hw/bttq_top.sv */
// The address map and the AXI4-Lite register port were chosen for this implementation.
`default_nettype none
module bttq_top (
    input  wire  logic                    aclk,
    input  wire  logic                    aresetn,
    input  wire  logic [7:0]              s_axi_awaddr,
    input  wire  logic                    s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire  logic [31:0]             s_axi_wdata,
    input  wire  logic [3:0]              s_axi_wstrb,
    input  wire  logic                    s_axi_wvalid,
    output logic                          s_axi_wready,
    output logic [1:0]                    s_axi_bresp,
    output logic                          s_axi_bvalid,
    input  wire  logic                    s_axi_bready,
    input  wire  logic [7:0]              s_axi_araddr,
    input  wire  logic                    s_axi_arvalid,
    output logic                          s_axi_arready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp,
    output logic                          s_axi_rvalid,
    input  wire  logic                    s_axi_rready,
    input  wire  bttq_pkg::bttq_cycle_t   bus_cyc,
    input  wire  logic                    bus_strobe,
    input  wire  bttq_pkg::bttq_cycle_t   aux_cyc,
    input  wire  logic                    aux_strobe,
    output bttq_pkg::bttq_cycle_t         store_cyc,
    output logic                          store_strobe,
    output logic                          trig_strobe,
    output logic                          irq_req,
    output logic [3:0]                    irq_level,
    output bttq_pkg::bttq_state_t         trace_state
);
    import bttq_pkg::*;
    localparam int UW = $clog2(CYC_PER_US);

    // ==========================================
    // match functions
    function automatic logic [2:0] fmatch(input logic [3:0][31:0] w, input bttq_cycle_t c);
        logic        lg;
        logic [15:0] lv;
        logic [3:0]  pt;
        logic        dh;
        logic        ah;
        logic        oh;
        lg = w[3][W_LOGICAL];
        lv = w[2][31:16];
        pt = w[3][19:16];
        dh = ((c.data ^ w[0][15:0]) & w[0][31:16]) == 16'h0000;
        ah = (((lg ? c.laddr : c.paddr) ^ w[1][15:0]) & w[1][31:16]) == 16'h0000;
        oh = (((c.ctl ^ w[3][6:0]) & w[3][14:8]) == 7'h00) && lv[c.level]
             && (lg ? pt[c.ptab] : (((c.bank ^ w[2][7:0]) & w[2][15:8]) == 8'h00));
        return {dh, ah, oh};
    endfunction

    function automatic logic ghit(input logic [3:0][3:0][31:0] ws, input bttq_cycle_t c,
                                  input logic [2:0] md, input logic [3:0] en);
        logic [3:0] d;
        logic [3:0] a;
        logic [3:0] o;
        logic [2:0] m;
        for (int i = 0; i < 4; i++) begin
            m    = fmatch(ws[i], c);
            d[i] = m[2];
            a[i] = m[1];
            o[i] = m[0];
        end
        case (md)
            3'h1:    return en[0] & a[0] & o[0] & ~d[0];
            3'h2:    return en[0] & a[0] & o[0] & |(en & d);
            3'h3,
            3'h4:    return en[0] & d[0] & o[0] & |(en & a);
            default: return |(en & d & a & o);
        endcase
    endfunction

    function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                o[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return o;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && (a[7:6] == REG_QUAL || a[7:6] == REG_TRIG || a <= OFS_STAT);
    endfunction

    // ==========================================
    // register file and axi4-lite slave
    logic [7:0][3:0][31:0] words, next_words;
    bttq_mode_t            mode, next_mode;
    logic [15:0]           post, next_post;
    logic                  next_awready, next_bvalid, next_arready, next_rvalid;
    logic [1:0]            next_bresp, next_rresp;
    logic [31:0]           next_rdata, wr_val, mtmp;
    logic [2:0]            wi;
    logic [1:0]            fi;
    logic                  start_req, abort_req;
    logic [15:0]           stored;
    logic [1:0]            seq_cnt;
    logic                  int_on;

    assign s_axi_wready = s_axi_awready;

    always_comb begin
        next_words   = words;
        next_mode    = mode;
        next_post    = post;
        start_req    = 1'b0;
        abort_req    = 1'b0;
        wi           = {s_axi_awaddr[7], s_axi_awaddr[5:4]};
        fi           = s_axi_awaddr[3:2];
        wr_val       = bmerge(words[wi][fi], s_axi_wdata, s_axi_wstrb);
        mtmp         = bmerge({16'h0000, mode}, s_axi_wdata, s_axi_wstrb);
        next_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
        next_bvalid  = s_axi_bvalid && !s_axi_bready;
        next_bresp   = s_axi_bresp;
        if (s_axi_awready && s_axi_awvalid) begin
            next_bvalid = 1'b1;
            next_bresp  = mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLV;
            if (s_axi_awaddr[1:0] != 2'h0) begin
                next_bresp = RESP_SLV;
            end else if (s_axi_awaddr[7:6] == REG_QUAL || s_axi_awaddr[7:6] == REG_TRIG) begin
                if (fi == 2'h3 && (wi[2] ? (mode.tmode == TM_LAINT || mode.tmode == TM_PAINT)
                                         : (mode.qmode == QM_LAINT || mode.qmode == QM_PAINT))) begin
                    wr_val[W_LOGICAL] = words[wi][fi][W_LOGICAL];
                end
                next_words[wi][fi] = wr_val;
            end else begin
                case (s_axi_awaddr)
                    OFS_CTRL: begin
                        start_req = s_axi_wstrb[0] & s_axi_wdata[CTRL_START];
                        abort_req = s_axi_wstrb[0] & s_axi_wdata[CTRL_ABORT];
                    end
                    OFS_MODE: next_mode = bttq_mode_t'(mtmp[15:0]);
                    OFS_POST: next_post = 16'(bmerge({16'h0000, post}, s_axi_wdata, s_axi_wstrb));
                    default:  ;
                endcase
            end
        end
    end

    always_comb begin
        next_arready = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        next_rvalid  = s_axi_rvalid && !s_axi_rready;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        if (s_axi_arready && s_axi_arvalid) begin
            next_rvalid = 1'b1;
            next_rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLV;
            next_rdata  = 32'h0000_0000;
            if (!mapped(s_axi_araddr)) begin
                next_rdata = 32'h0000_0000;
            end else if (s_axi_araddr[7:6] != 2'h0) begin
                next_rdata = words[{s_axi_araddr[7], s_axi_araddr[5:4]}][s_axi_araddr[3:2]];
            end else begin
                case (s_axi_araddr)
                    OFS_MODE: next_rdata = {16'h0000, mode};
                    OFS_POST: next_rdata = {16'h0000, post};
                    OFS_STAT: next_rdata = {stored, 9'h000, int_on, seq_cnt, 1'b0, trace_state};
                    default:  next_rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 8; i++) begin
                words[i] <= {(i == 0) ? F3_Q0_RST : F3_RST, F2_RST, 32'h0000_0000, 32'h0000_0000};
            end
            mode          <= MODE_RST;
            post          <= POST_RST;
            s_axi_awready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            words         <= next_words;
            mode          <= next_mode;
            post          <= next_post;
            s_axi_awready <= next_awready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    // ==========================================
    // strobe synchronisers and cycle capture
    logic [2:0]  bsync, async, next_bsync, next_async;
    logic        bflt, aflt, next_bflt, next_aflt, ev, next_ev, rise;
    bttq_cycle_t cyc, next_cyc;

    always_comb begin
        next_bsync = {bsync[1:0], bus_strobe};
        next_async = {async[1:0], aux_strobe};
        next_bflt  = (bsync[1] == bsync[2]) ? bsync[2] : bflt;
        next_aflt  = (async[1] == async[2]) ? async[2] : aflt;
        rise       = mode.ptab_only ? (next_aflt & ~aflt) : (next_bflt & ~bflt);
        next_ev    = rise && (!mode.ptab_only || aux_cyc.ptab_ref);
        next_cyc   = cyc;
        if (rise) begin
            next_cyc = mode.ptab_only ? aux_cyc : bus_cyc;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bsync <= 3'h0;
            async <= 3'h0;
            bflt  <= 1'b0;
            aflt  <= 1'b0;
            ev    <= 1'b0;
            cyc   <= '0;
        end else begin
            bsync <= next_bsync;
            async <= next_async;
            bflt  <= next_bflt;
            aflt  <= next_aflt;
            ev    <= next_ev;
            cyc   <= next_cyc;
        end
    end

    // ==========================================
    // qualification, trig and trace control
    logic [UW-1:0] usdiv, next_usdiv;
    logic [31:0]   iof_us, next_iof_us, per_us, next_per_us, thr;
    logic [15:0]   postcnt, next_postcnt, next_stored;
    logic [1:0]    next_seq_cnt;
    logic [2:0]    sl, cnt1;
    logic [3:0]    qen, ten;
    logic          tick, qhit, thit, arm_hit, trig, next_int_on;
    logic          next_store, next_trig, next_irq;
    bttq_state_t   next_st;
    bttq_cycle_t   next_store_cyc;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            qen[i] = words[i][3][W_EN];
            ten[i] = words[i + 4][3][W_EN];
        end
        qhit    = ghit(words[3:0], cyc, (mode.qmode == QM_ARM) ? 3'h0 : 3'(mode.qmode),
                       (mode.qmode == QM_ARM) ? (qen & 4'hE) : qen);
        arm_hit = ghit(words[3:0], cyc, 3'h0, qen & 4'h1);
        thit    = ghit(words[7:4], cyc, (mode.tmode <= TM_PAINT) ? 3'(mode.tmode) : 3'h0, ten);
        sl      = (mode.seq_len < SEQ_MIN) ? SEQ_MIN : (mode.seq_len > SEQ_MAX) ? SEQ_MAX : mode.seq_len;
        cnt1    = {1'b0, seq_cnt} + 3'h1;
        thr     = 32'h0000_0001 << mode.pwr;
        tick    = usdiv == UW'(CYC_PER_US - 1);
        next_usdiv     = tick ? '0 : usdiv + UW'(1);
        next_int_on    = ev ? cyc.ctl[CB_ION] : int_on;
        next_iof_us    = int_on ? 32'h0000_0000 : (tick && iof_us != 32'hFFFF_FFFF) ? iof_us + 32'h1 : iof_us;
        next_per_us    = per_us;
        next_irq       = 1'b0;
        next_st        = trace_state;
        next_seq_cnt   = seq_cnt;
        next_postcnt   = postcnt;
        next_stored    = stored;
        next_store     = 1'b0;
        next_store_cyc = store_cyc;
        next_trig      = 1'b0;
        trig           = 1'b0;
        if (mode.tmode != TM_LVL17) begin
            next_per_us = 32'h0000_0000;
        end else if (tick) begin
            next_per_us = per_us + 32'h1;
            if (per_us + 32'h1 >= thr) begin
                next_per_us = 32'h0000_0000;
                next_irq    = 1'b1;
            end
        end
        unique case (trace_state)
            ST_IDLE, ST_DONE: ;
            ST_ARMWAIT: begin
                if (ev && arm_hit) begin
                    next_st = ST_COLLECT;
                end
            end
            ST_COLLECT: begin
                next_store = ev && qhit;
                if (mode.tmode == TM_SEQ) begin
                    if (ev && (!mode.seq_qual || qhit)) begin
                        next_seq_cnt = 2'h0;
                        if (thit && cnt1 >= sl) begin
                            trig = 1'b1;
                        end else if (thit) begin
                            next_seq_cnt = cnt1[1:0];
                        end
                    end
                end else if (mode.tmode == TM_IOF) begin
                    trig = iof_us > thr;
                end else if (mode.tmode != TM_LVL17) begin
                    trig = ev && thit;
                end
                if (trig) begin
                    next_trig    = 1'b1;
                    next_st      = (post == 16'h0000) ? ST_DONE : ST_POST;
                    next_postcnt = post;
                end
            end
            ST_POST: begin
                next_store = ev && qhit;
                if (ev && qhit) begin
                    next_postcnt = postcnt - 16'h1;
                    if (postcnt == 16'h0001) begin
                        next_st = ST_DONE;
                    end
                end
            end
        endcase
        if (next_store) begin
            next_store_cyc = cyc;
            next_stored    = stored + 16'h1;
        end
        if (start_req) begin
            next_st      = (mode.qmode == QM_ARM) ? ST_ARMWAIT : ST_COLLECT;
            next_seq_cnt = 2'h0;
            next_stored  = 16'h0000;
        end else if (abort_req) begin
            next_st = ST_DONE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            usdiv        <= '0;
            iof_us       <= 32'h0000_0000;
            per_us       <= 32'h0000_0000;
            int_on       <= 1'b0;
            postcnt      <= POST_RST;
            stored       <= 16'h0000;
            seq_cnt      <= 2'h0;
            trace_state  <= ST_IDLE;
            store_strobe <= 1'b0;
            store_cyc    <= '0;
            trig_strobe  <= 1'b0;
            irq_req      <= 1'b0;
            irq_level    <= LVL17;
        end else begin
            usdiv        <= next_usdiv;
            iof_us       <= next_iof_us;
            per_us       <= next_per_us;
            int_on       <= next_int_on;
            postcnt      <= next_postcnt;
            stored       <= next_stored;
            seq_cnt      <= next_seq_cnt;
            trace_state  <= next_st;
            store_strobe <= next_store;
            store_cyc    <= next_store_cyc;
            trig_strobe  <= next_trig;
            irq_req      <= next_irq;
            irq_level    <= LVL17;
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_live;
        !start_req && !abort_req;
    endsequence
    sequence s_seq_ev;
        (trace_state == ST_COLLECT && mode.tmode == TM_SEQ && ev) and s_live;
    endsequence

    chk_no_store_idle: assert property ((trace_state inside {ST_IDLE, ST_ARMWAIT, ST_DONE}) |=> !store_strobe)
        else $error("store while not collecting");
    chk_arm_enter: assert property ((trace_state == ST_ARMWAIT && ev && arm_hit) and s_live
                                    |=> trace_state == ST_COLLECT)
        else $error("arm match did not start collection");
    chk_trig_stop: assert property ((trace_state == ST_COLLECT && trig && post == 16'h0000) and s_live
                                    |=> trig_strobe && trace_state == ST_DONE ##1 !store_strobe)
        else $error("immediate stop failed");
    chk_seq_clear: assert property (s_seq_ev and (!thit && (!mode.seq_qual || qhit)) |=> seq_cnt == 2'h0)
        else $error("sequence counter not cleared");
    chk_seq_count: assert property (s_seq_ev and (thit && (!mode.seq_qual || qhit) && cnt1 < sl)
                                    |=> seq_cnt == $past(seq_cnt) + 2'h1)
        else $error("sequence counter not advanced");
    chk_seq_qual: assert property (s_seq_ev and (mode.seq_qual && !qhit) |=> $stable(seq_cnt))
        else $error("unqualified event moved sequence");
    chk_ptab_src: assert property (ev |-> !$past(mode.ptab_only) || cyc.ptab_ref)
        else $error("non page-table cycle accepted");
    chk_qual_store: assert property ((trace_state == ST_COLLECT && ev && qhit) and s_live
                                     |=> store_strobe && store_cyc == $past(cyc))
        else $error("qualified cycle not stored");
    chk_iof_trig: assert property ((trace_state == ST_COLLECT && mode.tmode == TM_IOF && iof_us > thr)
                                   and s_live |=> trig_strobe)
        else $error("interrupts-off trig missed");
    chk_lvl17: assert property (irq_req |-> irq_level == 4'hF && $past(mode.tmode) == TM_LVL17 ##1 !irq_req)
        else $error("bad level 17 request");
    chk_word_lock: assert property (s_axi_awready && s_axi_awvalid && s_axi_awaddr == OFS_QUAL + 8'h0C
                                    && mode.qmode == QM_LAINT |=> $stable(words[0][3][W_LOGICAL]))
        else $error("address mode changed under interval");
endmodule
`default_nettype wire

/* File: tb/bttq_bus_model.sv */
`default_nettype none
module bttq_bus_model (
    input  wire logic                  aclk,
    input  wire logic                  send,
    input  wire bttq_pkg::bttq_cycle_t cyc_in,
    output bttq_pkg::bttq_cycle_t      bus_cyc,
    output logic                       bus_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    import bttq_pkg::*;
    logic [3:0] cnt = 4'h0;
    // strobe high 6 cycles, then low 6; released data inverted
    always @(posedge aclk) begin
        if (send) begin
            bus_cyc <= cyc_in;
            cnt     <= 4'hC;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
        if (cnt == 4'h5) begin
            bus_cyc <= ~bus_cyc;
        end
    end
    assign bus_strobe = (cnt > 4'h6);
endmodule
`default_nettype wire

/* File: tb/bttq_top_tb.sv */
`default_nettype none
module bttq_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bttq_pkg::*;
    typedef struct packed {
        logic [15:0] mode;
        logic        start;
        logic [15:0] data;
        logic        store;
        logic        trig;
    } bttq_row_t;
    localparam bttq_row_t ROWS [8] = '{
        '{16'h0000, 1'b1, 16'h1235, 1'b1, 1'b0}, '{16'h0000, 1'b0, 16'h0234, 1'b1, 1'b0},
        '{16'h0000, 1'b0, 16'h1234, 1'b1, 1'b1}, '{16'h0000, 1'b0, 16'h1234, 1'b0, 1'b0},
        '{16'h0250, 1'b1, 16'h1234, 1'b1, 1'b0}, '{16'h0250, 1'b0, 16'h1111, 1'b1, 1'b0},
        '{16'h0250, 1'b0, 16'h1234, 1'b1, 1'b0}, '{16'h0250, 1'b0, 16'h1234, 1'b1, 1'b1}};
    logic        aclk = 1'b0, aresetn = 1'b0, send = 1'b0, awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [1:0]  bresp, rresp, rr;
    logic        awready, wready, bvalid, arready, rvalid, store_strobe, trig_strobe, irq_req, bus_strobe;
    logic [3:0]  irq_level;
    bttq_cycle_t cyc = '0, bus_cyc, store_cyc;
    bttq_state_t trace_state;
    int          err_total = 0, n_compared = 0, n;
    always #10 aclk = ~aclk;
    bttq_bus_model i_bttq_bus_model (.aclk(aclk), .send(send), .cyc_in(cyc), .bus_cyc(bus_cyc),
        .bus_strobe(bus_strobe));
    bttq_top i_bttq_top (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .bus_cyc(bus_cyc), .bus_strobe(bus_strobe), .aux_cyc('0),
        .aux_strobe(1'b0), .store_cyc(store_cyc), .store_strobe(store_strobe), .trig_strobe(trig_strobe),
        .irq_req(irq_req), .irq_level(irq_level), .trace_state(trace_state));
    task automatic conclude();
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ready lines held high, so each answer is taken where it is seen
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge aclk); while (bvalid !== 1'b1);
    endtask
    task automatic axr(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rd = rdata;
        rr = rresp;
    endtask
    // one observed cycle, then watch for store and trig pulses
    task automatic ev(input logic [15:0] d, input logic es, input logic et);
        logic        s = 1'b0;
        logic        t = 1'b0;
        logic [15:0] sd = 16'h0;
        cyc.data <= d;
        send     <= 1'b1;
        @(posedge aclk);
        send <= 1'b0;
        repeat (14) begin
            @(posedge aclk);
            if (store_strobe === 1'b1) begin
                s  = 1'b1;
                sd = store_cyc.data;
            end
            t = t | (trig_strobe === 1'b1);
        end
        cmp({sd, 14'h0, s, t}, {es ? d : 16'h0, 14'h0, es, et});
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        cmp({29'h0, trace_state}, {29'h0, ST_IDLE});
        cmp({28'h0, irq_level}, {28'h0, LVL17});
        axr(8'hFC);
        cmp({30'h0, rr}, {30'h0, RESP_SLV});
        axw(OFS_TRIG, 32'hFFFF_1234);
        axw(OFS_TRIG + 8'h0C, F3_Q0_RST);
        foreach (ROWS[i]) begin
            if (ROWS[i].start) begin
                axw(OFS_MODE, {16'h0, ROWS[i].mode});
                axw(OFS_CTRL, 32'h1);
            end
            ev(ROWS[i].data, ROWS[i].store, ROWS[i].trig);
        end
        axr(OFS_STAT);
        cmp({29'h0, rd[2:0]}, {29'h0, ST_DONE});
        axw(OFS_QUAL, 32'hFFFF_0000);
        axw(OFS_MODE, 32'h0000_0001);
        axw(OFS_CTRL, 32'h1);
        ev(16'h0000, 1'b0, 1'b0);
        ev(16'h0005, 1'b1, 1'b0);
        axw(OFS_MODE, 32'h0000_0003);
        axw(OFS_QUAL + 8'h0C, 32'hC00F_0000);
        axr(OFS_QUAL + 8'h0C);
        cmp(rd, F3_Q0_RST);
        axw(OFS_MODE, 32'h0000_0005);
        axw(OFS_CTRL, 32'h1);
        ev(16'h1234, 1'b0, 1'b0);
        ev(16'h0000, 1'b0, 1'b0);
        axw(OFS_QUAL + 8'h1C, 32'h800F_0000);
        ev(16'h1234, 1'b1, 1'b1);
        axw(OFS_MODE, 32'h0000_0070);
        repeat (60) @(posedge aclk);
        n = 0;
        repeat (100) begin
            @(posedge aclk);
            n += int'(irq_req === 1'b1);
        end
        cmp(32'(n), 32'd2);
        conclude();
    end
    initial begin
        #100us;
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
